// file: logic/drive_data_map.vh
/*
  Constants for the drive data map: function codes, exception codes,
  diagnostics sub-functions, coil layout and holding register addresses.
  Assumes inclusion by bare name from the design files that need it.
*/
`ifndef DRIVE_DATA_MAP_VH
`define DRIVE_DATA_MAP_VH

`define FN_RD_COILS      8'h01
`define FN_RD_REGS       8'h03
`define FN_WR_COIL       8'h05
`define FN_WR_REG        8'h06
`define FN_DIAG          8'h08
`define FN_EVENT_CNT     8'h0B
`define FN_WR_COILS      8'h0F
`define FN_WR_REGS       8'h10
`define FN_SLAVE_ID      8'h11
`define FN_EXC_FLAG      8'h80

`define EXC_NONE         8'h00
`define EXC_ILL_FUNC     8'h01
`define EXC_ILL_ADDR     8'h02
`define EXC_ILL_VALUE    8'h03

`define SUB_RESTART      16'h0001
`define SUB_DIAG_REG     16'h0002
`define SUB_CLEAR        16'h000A
`define SUB_BUS_MSG      16'h000B
`define SUB_COMM_ERR     16'h000C
`define SUB_EXC_ERR      16'h000D
`define SUB_SLAVE_MSG    16'h000E

`define COIL_ON          16'hFF00
`define COIL_OFF         16'h0000
`define COIL_STATE_BASE  17'h00020
`define COIL_ACTUAL_END  17'h00040
`define COIL_COUNT       17'h00041
`define COIL_STORE       16'h0040

`define REG_LAST_FAULT   16'h0007
`define REG_ARRAY_INDEX  16'h0009
`define REG_BUS_CMD      16'hC350
`define REG_BUS_REF      16'hC35A
`define REG_STATE_WORD   16'hC418
`define REG_MAIN_ACTUAL  16'hC422
`define REG_PARAM_FIRST  16'h000A
`define REG_PARAM_LAST   16'hC346
`define PARAM_SCALE      16'h000A

`define CLS_NONE         3'h0
`define CLS_FAULT        3'h1
`define CLS_INDEX        3'h2
`define CLS_CMD          3'h3
`define CLS_REF          3'h4
`define CLS_STATE        3'h5
`define CLS_ACTUAL       3'h6
`define CLS_PARAM        3'h7

`endif

// file: logic/hold_reg_decode.v
/*
  Holding register address decoder: sorts a zero-based register address
  into its class and, for parameter addresses, yields the parameter number.
  Assumes a stable address; purely combinational.
*/
`include "drive_data_map.vh"

module hold_reg_decode
(
  input  wire [15:0] addr,
  output reg  [2:0]  cls,
  output wire [15:0] param_num,
  output wire        writable
);

  wire [15:0] quot;
  wire [15:0] rem;

  // Parameter number times ten gives the register address
  assign quot      = addr / `PARAM_SCALE;
  assign rem       = addr - quot * `PARAM_SCALE;
  assign param_num = quot;
  assign writable  = (cls == `CLS_INDEX) || (cls == `CLS_CMD) || (cls == `CLS_REF) || (cls == `CLS_PARAM);

  always @*
  begin
    cls = `CLS_NONE;
    case (addr)
      `REG_LAST_FAULT:  cls = `CLS_FAULT;
      `REG_ARRAY_INDEX: cls = `CLS_INDEX;
      `REG_BUS_CMD:     cls = `CLS_CMD;
      `REG_BUS_REF:     cls = `CLS_REF;
      `REG_STATE_WORD:  cls = `CLS_STATE;
      `REG_MAIN_ACTUAL: cls = `CLS_ACTUAL;
      default:
      begin
        if (addr >= `REG_PARAM_FIRST && addr <= `REG_PARAM_LAST && rem == 16'h0000)
          cls = `CLS_PARAM;
      end
    endcase
  end

endmodule // hold_reg_decode

// file: logic/modbus_drive_data_map.v
/*
  Data map and function decoder of a drive on Modbus RTU.
  Keeps command, reference, index and store coil.
  Executes decoded requests one coil or one register word at a time.
  Assumes framing, silence timing and CRC are done upstream;
  a request comes as function, address, quantity and data.
*/
// Function
// - Coils hold one bit, holding registers 16 bits.
// - Coil N travels as zero-based address N-1.
// - Register 4xxxx travels zero-based without prefix.
// - Coils 1-16 hold the command word.
// - Coils 17-32 hold the speed reference.
// - Coils 33-48 hold the status word.
// - Coils 49-64 report output frequency or feedback.
// - Coil 65 selects volatile or also nonvolatile stores.
// - Command coils decode into drive controls.
// - Coils 33-43: ready, alarm, warning, reference, mode.
// - Coils 44-48: running, voltage, current, thermal.
// - Register 7 is last fault; 1-6 and 8 reserved.
// - Register 9 holds the array index.
// - Parameters fill register blocks by group.
// - Register 50000 accepts the command word.
// - Register 50010 accepts the bus reference.
// - Register 50200 presents the status word.
// - Register 50210 presents the main actual value.
// - Function codes 1, 3, 5, 6, F, 10 hex.
// - B hex gives event count, 11 hex slave ID.
// - Diagnostics 8: sub-functions 1, 2, 10 to 14.
// - Error reply sets function top bit, adds exception code.
// - Exception 1 bad function, 2 bad address and length.
// - Parameter number times ten gives register address.
`include "drive_data_map.vh"

module modbus_drive_data_map
#(
  parameter [7:0] SLAVE_ID = 8'h5A // Arbitrary value
)
(
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        req_valid,
  input  wire [7:0]  req_func,
  input  wire [15:0] req_addr,
  input  wire [15:0] req_qty,
  input  wire [15:0] req_data,
  output reg         req_ready,
  input  wire        wr_word_valid,
  input  wire [15:0] wr_word,
  output reg         wr_word_ready,
  output reg         rd_word_valid,
  output reg  [15:0] rd_word,
  output reg         rsp_valid,
  output reg  [7:0]  rsp_func,
  output reg  [7:0]  rsp_exc,
  output reg  [15:0] rsp_data,
  input  wire        frame_seen,
  input  wire        frame_crc_err,
  output reg         param_req,
  output reg         param_we,
  output reg  [15:0] param_num,
  output reg  [15:0] param_wdata,
  output wire [15:0] param_index,
  output wire        param_nv,
  input  wire        param_ack,
  input  wire [15:0] param_rdata,
  output wire [15:0] cmd_word,
  output wire [15:0] speed_ref,
  output reg  [1:0]  preset_sel,
  output reg         dc_brake,
  output reg         coast_stop,
  output reg         quick_stop,
  output reg         freeze_freq,
  output reg         start_run,
  output reg         fault_reset,
  output reg         jog,
  output reg         ramp2_sel,
  output reg         data_valid,
  output reg         relay1_on,
  output reg         relay2_on,
  output reg  [1:0]  setup_sel,
  output reg         reverse,
  input  wire        st_ctl_ready,
  input  wire        st_drive_ready,
  input  wire        st_safety_closed,
  input  wire        st_alarm,
  input  wire        st_warning,
  input  wire        st_at_ref,
  input  wire        st_auto,
  input  wire        st_in_range,
  input  wire        st_running,
  input  wire        st_volt_warn,
  input  wire        st_curr_limit,
  input  wire        st_therm_warn,
  input  wire [15:0] main_actual,
  input  wire [15:0] output_value,
  input  wire [15:0] last_fault
);

  localparam [2:0] S_IDLE  = 3'h0;
  localparam [2:0] S_CHECK = 3'h1;
  localparam [2:0] S_EXEC  = 3'h2;
  localparam [2:0] S_PARAM = 3'h3;
  localparam [2:0] S_DONE  = 3'h4;

  reg  [2:0]  state_ff;
  reg  [7:0]  func_ff;
  reg  [15:0] addr_ff;
  reg  [15:0] qty_ff;
  reg  [15:0] data_ff;
  reg  [15:0] idx_ff;
  reg  [7:0]  exc_ff;
  reg  [15:0] acc_ff;
  reg  [3:0]  bitn_ff;
  reg  [15:0] inword_ff;
  reg         have_ff;
  reg  [15:0] cmd_ff;
  reg  [15:0] speed_ff;
  reg  [15:0] index_ff;
  reg         store_ff;
  reg  [15:0] state_word_ff;
  reg  [15:0] bus_msg_ff;
  reg  [15:0] comm_err_ff;
  reg  [15:0] exc_cnt_ff;
  reg  [15:0] slave_msg_ff;
  reg  [15:0] event_cnt_ff;
  reg  [15:0] diag_reg_ff;

  wire [15:0] cur;
  wire [2:0]  cls;
  wire [15:0] cur_pnum;
  wire        cur_wr_ok;
  wire [64:0] coil_vec;
  wire        is_coil;
  wire        is_write;
  wire        is_multi_wr;
  wire        last;
  wire        need_word;
  wire        take;
  wire        wr_bit;
  wire [15:0] wr_val;
  wire [15:0] nacc;
  wire [16:0] coil_end;
  wire        supported;
  wire        sub_ok;
  wire        clr;
  wire        done;
  wire [15:0] reg_val;

  assign cur         = addr_ff + idx_ff;
  assign is_coil     = (func_ff == `FN_RD_COILS) || (func_ff == `FN_WR_COIL) || (func_ff == `FN_WR_COILS);
  assign is_write    = (func_ff == `FN_WR_COIL) || (func_ff == `FN_WR_COILS) ||
                       (func_ff == `FN_WR_REG) || (func_ff == `FN_WR_REGS);
  assign is_multi_wr = (func_ff == `FN_WR_COILS) || (func_ff == `FN_WR_REGS);
  assign last        = (idx_ff == qty_ff - 16'h0001);
  assign need_word   = ((func_ff == `FN_WR_COILS && bitn_ff == 4'h0) || func_ff == `FN_WR_REGS) && !have_ff;
  assign take        = wr_word_valid && wr_word_ready;
  // Coil map: command, reference, status, actual output, store select
  assign coil_vec    = {store_ff, output_value, state_word_ff, speed_ff, cmd_ff};
  assign wr_bit      = (func_ff == `FN_WR_COIL) ? (data_ff == `COIL_ON) : inword_ff[bitn_ff];
  assign wr_val      = (func_ff == `FN_WR_REG) ? data_ff : inword_ff;
  assign nacc        = acc_ff | ({15'h0000, coil_vec[cur[6:0]]} << bitn_ff);
  assign coil_end    = {1'b0, addr_ff} + {1'b0, qty_ff};
  assign supported   = is_coil || is_write || (func_ff == `FN_RD_REGS) || (func_ff == `FN_DIAG) ||
                       (func_ff == `FN_EVENT_CNT) || (func_ff == `FN_SLAVE_ID);
  assign sub_ok      = (addr_ff == `SUB_RESTART) || (addr_ff == `SUB_DIAG_REG) ||
                       (addr_ff >= `SUB_CLEAR && addr_ff <= `SUB_SLAVE_MSG);
  assign done        = (state_ff == S_DONE);
  assign clr         = done && func_ff == `FN_DIAG && exc_ff == `EXC_NONE &&
                       (addr_ff == `SUB_RESTART || addr_ff == `SUB_CLEAR);
  assign cmd_word    = cmd_ff;
  assign speed_ref   = speed_ff;
  assign param_index = index_ff;
  assign param_nv    = store_ff;

  hold_reg_decode u_dec
  (
    .addr      (cur),
    .cls       (cls),
    .param_num (cur_pnum),
    .writable  (cur_wr_ok)
  );

  reg [15:0] reg_mux;
  always @*
  begin
    reg_mux = 16'h0000;
    case (cls)
      `CLS_FAULT:  reg_mux = last_fault;
      `CLS_INDEX:  reg_mux = index_ff;
      `CLS_CMD:    reg_mux = cmd_ff;
      `CLS_REF:    reg_mux = speed_ff;
      `CLS_STATE:  reg_mux = state_word_ff;
      `CLS_ACTUAL: reg_mux = main_actual;
      default:     reg_mux = 16'h0000;
    endcase
  end
  assign reg_val = reg_mux;

  // Status word bits 33..48; unused positions read zero
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
      state_word_ff <= 16'h0000;
    else
      state_word_ff <= {st_therm_warn, st_curr_limit, st_volt_warn, 1'b0, st_running,
                        st_in_range, st_auto, st_at_ref, st_warning, 3'b000,
                        st_alarm, st_safety_closed, st_drive_ready, st_ctl_ready};
  end

  // Command word decoded to active-high controls; zero-active bits inverted
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      preset_sel  <= 2'h0;
      dc_brake    <= 1'b0;
      coast_stop  <= 1'b0;
      quick_stop  <= 1'b0;
      freeze_freq <= 1'b0;
      start_run   <= 1'b0;
      fault_reset <= 1'b0;
      jog         <= 1'b0;
      ramp2_sel   <= 1'b0;
      data_valid  <= 1'b0;
      relay1_on   <= 1'b0;
      relay2_on   <= 1'b0;
      setup_sel   <= 2'h0;
      reverse     <= 1'b0;
    end
    else
    begin
      preset_sel  <= cmd_ff[1:0];
      dc_brake    <= !cmd_ff[2];
      coast_stop  <= !cmd_ff[3];
      quick_stop  <= !cmd_ff[4];
      freeze_freq <= !cmd_ff[5];
      start_run   <= cmd_ff[6];
      fault_reset <= cmd_ff[7];
      jog         <= cmd_ff[8];
      ramp2_sel   <= cmd_ff[9];
      data_valid  <= cmd_ff[10];
      relay1_on   <= cmd_ff[11];
      relay2_on   <= cmd_ff[12];
      setup_sel   <= cmd_ff[14:13];
      reverse     <= cmd_ff[15];
    end
  end

  // Counters: a frame event in the clearing cycle is still counted
  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      bus_msg_ff   <= 16'h0000;
      comm_err_ff  <= 16'h0000;
      exc_cnt_ff   <= 16'h0000;
      slave_msg_ff <= 16'h0000;
      event_cnt_ff <= 16'h0000;
      diag_reg_ff  <= 16'h0000;
    end
    else if (clr)
    begin
      bus_msg_ff   <= {15'h0000, frame_seen};
      comm_err_ff  <= {15'h0000, frame_crc_err};
      exc_cnt_ff   <= 16'h0000;
      slave_msg_ff <= 16'h0000;
      event_cnt_ff <= 16'h0000;
      diag_reg_ff  <= 16'h0000;
    end
    else
    begin
      bus_msg_ff  <= bus_msg_ff + {15'h0000, frame_seen};
      comm_err_ff <= comm_err_ff + {15'h0000, frame_crc_err};
      if (done)
        slave_msg_ff <= slave_msg_ff + 16'h0001;
      if (done && exc_ff != `EXC_NONE)
      begin
        exc_cnt_ff     <= exc_cnt_ff + 16'h0001;
        diag_reg_ff[0] <= 1'b1;
      end
      if (done && exc_ff == `EXC_NONE && func_ff != `FN_DIAG && func_ff != `FN_EVENT_CNT)
        event_cnt_ff <= event_cnt_ff + 16'h0001;
    end
  end

  always @(posedge core_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      state_ff      <= S_IDLE;
      func_ff       <= 8'h00;
      addr_ff       <= 16'h0000;
      qty_ff        <= 16'h0000;
      data_ff       <= 16'h0000;
      idx_ff        <= 16'h0000;
      exc_ff        <= `EXC_NONE;
      acc_ff        <= 16'h0000;
      bitn_ff       <= 4'h0;
      inword_ff     <= 16'h0000;
      have_ff       <= 1'b0;
      cmd_ff        <= 16'h0000;
      speed_ff      <= 16'h0000;
      index_ff      <= 16'h0000;
      store_ff      <= 1'b0;
      req_ready     <= 1'b0;
      wr_word_ready <= 1'b0;
      rd_word_valid <= 1'b0;
      rd_word       <= 16'h0000;
      rsp_valid     <= 1'b0;
      rsp_func      <= 8'h00;
      rsp_exc       <= `EXC_NONE;
      rsp_data      <= 16'h0000;
      param_req     <= 1'b0;
      param_we      <= 1'b0;
      param_num     <= 16'h0000;
      param_wdata   <= 16'h0000;
    end
    else
    begin
      rd_word_valid <= 1'b0;
      rsp_valid     <= 1'b0;
      wr_word_ready <= (state_ff == S_EXEC) && need_word && !take;
      if (take)
      begin
        inword_ff <= wr_word;
        have_ff   <= 1'b1;
      end
      case (state_ff)
        S_IDLE:
        begin
          req_ready <= 1'b1;
          if (req_valid && req_ready)
          begin
            req_ready <= 1'b0;
            func_ff   <= req_func;
            addr_ff   <= req_addr;
            qty_ff    <= (req_func == `FN_WR_COIL || req_func == `FN_WR_REG) ? 16'h0001 : req_qty;
            data_ff   <= req_data;
            idx_ff    <= 16'h0000;
            acc_ff    <= 16'h0000;
            bitn_ff   <= 4'h0;
            have_ff   <= 1'b0;
            exc_ff    <= `EXC_NONE;
            state_ff  <= S_CHECK;
          end
        end
        S_CHECK:
        begin
          if (!supported)
          begin
            exc_ff   <= `EXC_ILL_FUNC;
            state_ff <= S_DONE;
          end
          else if (func_ff == `FN_DIAG || func_ff == `FN_EVENT_CNT || func_ff == `FN_SLAVE_ID)
          begin
            if (func_ff == `FN_DIAG && !sub_ok)
              exc_ff <= `EXC_ILL_FUNC;
            state_ff <= S_DONE;
          end
          else if (qty_ff == 16'h0000 ||
                   (func_ff == `FN_WR_COIL && data_ff != `COIL_ON && data_ff != `COIL_OFF))
          begin
            exc_ff   <= `EXC_ILL_VALUE;
            state_ff <= S_DONE;
          end
          else if (is_coil)
          begin
            // Reserved coils, and writes into status or actual coils, are refused
            if (coil_end > `COIL_COUNT ||
                (is_write && {1'b0, addr_ff} < `COIL_ACTUAL_END && coil_end > `COIL_STATE_BASE))
            begin
              exc_ff   <= `EXC_ILL_ADDR;
              state_ff <= S_DONE;
            end
            else
              state_ff <= S_EXEC;
          end
          else
          begin
            // Whole range is vetted before any item takes effect
            if (cls == `CLS_NONE || (is_write && !cur_wr_ok) || {1'b0, cur} < {1'b0, addr_ff})
            begin
              exc_ff   <= `EXC_ILL_ADDR;
              state_ff <= S_DONE;
            end
            else if (last)
            begin
              idx_ff   <= 16'h0000;
              state_ff <= S_EXEC;
            end
            else
              idx_ff <= idx_ff + 16'h0001;
          end
        end
        S_EXEC:
        begin
          if (!need_word)
          begin
            if (is_coil)
            begin
              if (!is_write)
              begin
                if (bitn_ff == 4'hF || last)
                begin
                  rd_word       <= nacc;
                  rd_word_valid <= 1'b1;
                  acc_ff        <= 16'h0000;
                end
                else
                  acc_ff <= nacc;
              end
              else if (cur < 16'h0010)
                cmd_ff[cur[3:0]] <= wr_bit;
              else if (cur < 16'h0020)
                speed_ff[cur[3:0]] <= wr_bit;
              else if (cur == `COIL_STORE)
                store_ff <= wr_bit;
              bitn_ff <= bitn_ff + 4'h1;
              if (bitn_ff == 4'hF)
                have_ff <= 1'b0;
              idx_ff <= idx_ff + 16'h0001;
              if (last)
                state_ff <= S_DONE;
            end
            else if (cls == `CLS_PARAM)
            begin
              param_req   <= 1'b1;
              param_we    <= is_write;
              param_num   <= cur_pnum;
              param_wdata <= wr_val;
              state_ff    <= S_PARAM;
            end
            else
            begin
              if (is_write)
              begin
                have_ff <= 1'b0;
                case (cls)
                  `CLS_INDEX: index_ff <= wr_val;
                  `CLS_CMD:   cmd_ff   <= wr_val;
                  `CLS_REF:   speed_ff <= wr_val;
                  default:    index_ff <= index_ff;
                endcase
              end
              else
              begin
                rd_word       <= reg_val;
                rd_word_valid <= 1'b1;
              end
              idx_ff <= idx_ff + 16'h0001;
              if (last)
                state_ff <= S_DONE;
            end
          end
        end
        S_PARAM:
        begin
          if (param_ack)
          begin
            param_req <= 1'b0;
            have_ff   <= 1'b0;
            if (!param_we)
            begin
              rd_word       <= param_rdata;
              rd_word_valid <= 1'b1;
            end
            idx_ff   <= idx_ff + 16'h0001;
            state_ff <= last ? S_DONE : S_EXEC;
          end
        end
        S_DONE:
        begin
          rsp_valid <= 1'b1;
          rsp_exc   <= exc_ff;
          rsp_func  <= (exc_ff != `EXC_NONE) ? (func_ff | `FN_EXC_FLAG) : func_ff;
          rsp_data  <= is_multi_wr ? qty_ff : data_ff;
          if (exc_ff == `EXC_NONE)
          begin
            if (func_ff == `FN_EVENT_CNT)
              rsp_data <= event_cnt_ff;
            else if (func_ff == `FN_SLAVE_ID)
              rsp_data <= {SLAVE_ID, 8'hFF};
            else if (func_ff == `FN_DIAG)
            begin
              case (addr_ff)
                `SUB_DIAG_REG:  rsp_data <= diag_reg_ff;
                `SUB_BUS_MSG:   rsp_data <= bus_msg_ff;
                `SUB_COMM_ERR:  rsp_data <= comm_err_ff;
                `SUB_EXC_ERR:   rsp_data <= exc_cnt_ff;
                `SUB_SLAVE_MSG: rsp_data <= slave_msg_ff;
                default:        rsp_data <= data_ff;
              endcase
            end
          end
          state_ff <= S_IDLE;
        end
        default: state_ff <= S_IDLE;
      endcase
    end
  end

endmodule // modbus_drive_data_map

// file: tb/drive_map_properties.sv
/* Checker of the data map's request, answer and decode timing.
   Assumes a bind to the top module by port name, one clock. */
module drive_map_checker (
  input wire        core_clk,
  input wire        rstn,
  input wire        req_valid,
  input wire        req_ready,
  input wire [7:0]  req_func,
  input wire [15:0] req_addr,
  input wire        rsp_valid,
  input wire [7:0]  rsp_func,
  input wire [7:0]  rsp_exc,
  input wire        rd_word_valid,
  input wire [15:0] rd_word,
  input wire [15:0] main_actual,
  input wire        param_req,
  input wire        param_ack,
  input wire [15:0] param_num,
  input wire [15:0] cmd_word,
  input wire        start_run,
  input wire        coast_stop,
  input wire        reverse
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire       take = req_valid && req_ready;
  reg [15:0] addr_ff;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
      addr_ff <= 16'h0000;
    else if (take)
      addr_ff <= req_addr;
  rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid && req_ready) else $error("answer pulse");
  busy_refuse_a: assert property (take |=> !req_ready [*2]) else $error("ready while busy");
  exc_flag_a: assert property (rsp_valid && rsp_exc != 8'h00 |-> rsp_func[7]) else $error("flag bit");
  bad_func_a: assert property (take && req_func == 8'h02 |-> ##[2:4] (rsp_valid && rsp_func == 8'h82 &&
    rsp_exc == 8'h01)) else $error("unsupported function");
  resv_coil_a: assert property (take && req_func == 8'h01 && req_addr == 16'h0041 |-> ##[2:4] (rsp_valid &&
    rsp_exc == 8'h02)) else $error("reserved coil");
  param_hold_a: assert property (param_req && !param_ack |=> param_req) else $error("request dropped");
  param_num_a: assert property ($rose(param_req) && addr_ff % 16'h000A == 16'h0000 |->
    param_num * 16'h000A == addr_ff) else $error("parameter number");
  read_actual_a: assert property (take && req_func == 8'h03 && req_addr == 16'hC422 |-> ##[2:8] (rd_word_valid &&
    rd_word == main_actual)) else $error("actual value");
  cmd_decode_a: assert property (rstn |=> start_run == $past(cmd_word[6]) && coast_stop == !$past(cmd_word[3]) &&
    reverse == $past(cmd_word[15])) else $error("command decode");
endmodule // drive_map_checker

bind modbus_drive_data_map drive_map_checker u_chk (.core_clk, .rstn, .req_valid, .req_ready, .req_func,
  .req_addr, .rsp_valid, .rsp_func, .rsp_exc, .rd_word_valid, .rd_word, .main_actual, .param_req, .param_ack,
  .param_num, .cmd_word, .start_run, .coast_stop, .reverse);

// file: tb/param_store_model.sv
/* Parameter store answering the map's parameter requests.
   Assumes one request at a time; slow adds nine wait cycles. */
module param_store_model (
  input  wire        core_clk,
  input  wire        rstn,
  input  wire        slow,
  input  wire        param_req,
  input  wire [15:0] param_num,
  output reg         param_ack,
  output reg  [15:0] param_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  reg [3:0] wait_ff;
  always @(posedge core_clk or negedge rstn)
    if (!rstn)
    begin
      param_ack <= 1'h0;
      param_rdata <= 16'h0000;
      wait_ff <= 4'h0;
    end
    else if (param_req && !param_ack && wait_ff == 4'h0)
    begin
      param_ack <= 1'h1;
      param_rdata <= {4'hA, param_num[11:0]};
    end
    else if (param_req && !param_ack)
      wait_ff <= wait_ff - 4'h1;
    else
    begin
      param_ack <= 1'h0;
      // Data toggles when idle so a stale capture cannot pass
      param_rdata <= ~param_rdata;
      wait_ff <= slow ? 4'h9 : 4'h0;
    end
endmodule // param_store_model

// file: tb/testbench.sv
/* Self-checking bench of the drive data map and its parameter store.
   Assumes one response pulse per request. */
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
    $display("wrong value at %0t: %h not %h", $time, g, e); end end
  logic core_clk = '0, rstn = '0, slow = '0, req_valid = '0, wr_word_valid = '0, frame_seen = '0, frame_crc_err = '0;
  logic [7:0] req_func = '0;
  logic [15:0] req_addr = '0, req_qty = '0, req_data = '0, wr_word = '0, st_w = 16'h8809, rd_last;
  logic [95:0] r;
  logic [31:0] sub_exp[3] = '{32'h000B0003, 32'h000C0001, 32'h000D0000};
  wire req_ready, wr_word_ready, rsp_valid, param_req, param_ack, param_nv, start_run, reverse, dc_brake, fault_reset,
    rd_word_valid;
  wire [7:0] rsp_func, rsp_exc;
  wire [15:0] rsp_data, param_num, param_rdata, param_index, cmd_word, speed_ref, rd_word;
  wire [1:0] preset_sel;
  int fail_count = 0, total_checks = 0;
  // Row: function, address, quantity, data, answer function, exception, answer data, data checked
  logic [95:0] rows[] = '{96'h060009000112340600123401, 96'h06C35A000180000600800001,
    96'h060007000100018602000000, 96'h060008000100008602000000, 96'h020000000100008201000000,
    96'h08000F000100008801000000, 96'h010041000100008102000000, 96'h0500400001FF000500000000,
    96'h0500200001FF008502000000, 96'h050000000112348503000000, 96'h1100000001000011005AFF01,
    96'h080002000100000800000101, 96'h03C418000100000300880901, 96'h03C422000100000300A5C301,
    96'h0100300010000001003C5A01, 96'h010020001000000100880901, 96'h03000B000100008302000000,
    96'h03000A000100000300A00101, 96'h03C346000100000300A38701, 96'h03C346000200008302000000,
    96'h060014000100550600005501, 96'h03000700010000030000E701, 96'h030009000100000300123401,
    96'h0B0000000100000B00000000, 96'h030009000000008303000000, 96'h030001000100008302000000};
  always #5 core_clk = ~core_clk;
  modbus_drive_data_map u_dut (.core_clk, .rstn, .req_valid, .req_func, .req_addr, .req_qty, .req_data,
    .req_ready, .wr_word_valid, .wr_word, .wr_word_ready, .rd_word_valid, .rd_word, .rsp_valid, .rsp_func,
    .rsp_exc, .rsp_data, .frame_seen, .frame_crc_err, .param_req, .param_we(), .param_num, .param_wdata(),
    .param_index, .param_nv, .param_ack, .param_rdata, .cmd_word, .speed_ref, .preset_sel, .dc_brake,
    .coast_stop(), .quick_stop(), .freeze_freq(), .start_run, .fault_reset, .jog(), .ramp2_sel(), .data_valid(),
    .relay1_on(), .relay2_on(), .setup_sel(), .reverse, .st_ctl_ready(st_w[0]), .st_drive_ready(st_w[1]),
    .st_safety_closed(st_w[2]), .st_alarm(st_w[3]), .st_warning(st_w[7]), .st_at_ref(st_w[8]),
    .st_auto(st_w[9]), .st_in_range(st_w[10]), .st_running(st_w[11]), .st_volt_warn(st_w[13]),
    .st_curr_limit(st_w[14]), .st_therm_warn(st_w[15]), .main_actual(16'hA5C3), .output_value(16'h3C5A),
    .last_fault(16'h00E7));
  param_store_model u_store (.core_clk, .rstn, .slow, .param_req, .param_num, .param_ack, .param_rdata);
  task automatic req(input logic [7:0] f, input logic [15:0] a, q, d, w0 = '0, w1 = '0, input int nw = 0);
    logic [15:0] ws[2];
    int k;
    ws = '{w0, w1};
    k = 0;
    rd_last = 'x;
    {req_valid, req_func, req_addr, req_qty, req_data} <= {1'h1, f, a, q, d};
    do @(posedge core_clk); while (req_ready !== 1'h1);
    req_valid <= 1'h0;
    for (int i = 0; i < 300; i++)
    begin
      wr_word_valid <= k < nw;
      wr_word <= ws[k[0]];
      @(posedge core_clk);
      if (wr_word_valid && wr_word_ready === 1'h1) k++;
      if (rd_word_valid === 1'h1) rd_last = rd_word;
      if (rsp_valid === 1'h1) break;
    end
    wr_word_valid <= 1'h0;
  endtask
  task automatic report_and_stop;
    if (fail_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial
  begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'h1;
    repeat (2) @(posedge core_clk);
    foreach (rows[i])
    begin
      r = rows[i];
      req(r[95:88], r[87:72], r[71:56], r[55:40]);
      `CHK(rsp_func, r[39:32])
      `CHK(rsp_exc, r[31:24])
      if (r[0]) `CHK(r[95:88] < 8'h04 ? rd_last : rsp_data, r[23:8])
    end
    `CHK({param_index, param_nv, speed_ref}, 33'h024698000)
    req(8'h0F, 16'h0000, 16'h0020, 16'h0000, 16'h8041, 16'h7FFF, 2);
    @(posedge core_clk);
    `CHK({rsp_exc, cmd_word, speed_ref}, 40'h0080417FFF)
    `CHK({preset_sel, start_run, reverse, dc_brake, fault_reset}, 6'h1E)
    req(8'h10, 16'hC350, 16'h0001, 16'h0000, 16'h0080, 16'h0000, 1);
    @(posedge core_clk);
    `CHK({rsp_exc, cmd_word, fault_reset, start_run}, 26'h0000202)
    req(8'h0F, 16'h0020, 16'h0010, 16'h0000);
    `CHK({rsp_func, rsp_exc, cmd_word}, 32'h8F020080)
    st_w <= 16'h6786;
    req(8'h03, 16'hC418, 16'h0001, 16'h0000);
    `CHK(rd_last, 16'h6786)
    req(8'h08, 16'h000A, 16'h0001, 16'h0000);
    for (int i = 0; i < 3; i++)
    begin
      {frame_seen, frame_crc_err} <= {1'h1, i == 0};
      @(posedge core_clk);
      {frame_seen, frame_crc_err} <= 2'h0;
      @(posedge core_clk);
    end
    foreach (sub_exp[i])
    begin
      req(8'h08, sub_exp[i][31:16], 16'h0001, 16'h0000);
      `CHK(rsp_data, sub_exp[i][15:0])
    end
    req(8'h02, 16'h0000, 16'h0001, 16'h0000);
    req(8'h08, 16'h0001, 16'h0001, 16'h0000);
    req(8'h08, 16'h0002, 16'h0001, 16'h0000);
    `CHK(rsp_data, 16'h0000)
    // A stalling store must not be mistaken for a finished read
    slow <= 1'h1;
    req(8'h03, 16'h0014, 16'h0001, 16'h0000);
    `CHK(rd_last, 16'hA002)
    rstn <= 1'h0;
    @(posedge core_clk);
    `CHK({cmd_word, req_ready, rsp_valid}, 18'h00000)
    report_and_stop();
  end
  initial
  begin
    repeat (20000) @(posedge core_clk);
    fail_count++;
    report_and_stop();
  end
endmodule // testbench
